/* File: dv/cpu_bus_model.sv */
/*
 * cpu side of the peripheral bus: single write and read cycles.
 * assumes strobes sampled on the rising edge, read data one cycle later.
 */
`timescale 1ns/10ps
module cpu_bus_model (
    // clock
    input  wire        core_clk,
    // bus out
    output reg  [15:0] bus_addr,
    output reg  [15:0] bus_wdata,
    output reg         bus_write,
    output reg         bus_read,
    // bus in
    input  wire [15:0] bus_rdata
);
    initial begin
        bus_addr  = 16'h0000;
        bus_wdata = 16'h0000;
        bus_write = 1'b0;
        bus_read  = 1'b0;
    end
    task wr(input [15:0] a, input [15:0] d);
        begin
            @(negedge core_clk);
            bus_addr  = a;
            bus_wdata = d;
            bus_write = 1'b1;
            @(negedge core_clk);
            bus_write = 1'b0;
            bus_wdata = ~d;
        end
    endtask
    task rd(input [15:0] a, output [15:0] d);
        begin
            @(negedge core_clk);
            bus_addr = a;
            bus_read = 1'b1;
            @(negedge core_clk);
            bus_read = 1'b0;
            d        = bus_rdata;
        end
    endtask
endmodule // cpu_bus_model

/* File: dv/pll_clock_gen_sva.sv */
/*
 * port assertions for pll_clock_gen.
 * assumes WD_QUARTER_TICKS of 2 and attachment through the bind below.
 */
`timescale 1ns/10ps
module pll_clock_gen_chk #(
    parameter LOCK_CYCLES      = 20,
    parameter WD_QUARTER_TICKS = 2
) (
    // clock and reset
    input wire        core_clk,
    input wire        reset,
    // pins
    input wire        ref_clock_in,
    input wire        osc_bypass_select_n,
    input wire        crystal_drive_out,
    // bus
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire        bus_write,
    input wire        bus_read,
    input wire [15:0] bus_rdata,
    // idle
    input wire        idle_request,
    input wire        wake_request,
    // outputs
    input wire        core_clock_en,
    input wire        peripheral_clock_en,
    input wire        watchdog_tick_clock,
    input wire        pll_power_up,
    input wire        osc_power_down
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire       pri_sel = (bus_addr[15:1] == 15'h3815);
    reg [15:0] on_cnt;
    // --------------------------------------------------------------
    // pll on-time counter
    // --------------------------------------------------------------
    always @(posedge core_clk) begin
        if (reset || !pll_power_up)
            on_cnt <= 16'h0000;
        else if (on_cnt != 16'hFFFF)
            on_cnt <= on_cnt + 16'h0001;
    end
    AST_UPPER_ZERO: assert property (bus_rdata[15:8] == 8'h00)
        else $error("upper read byte not zero");
    AST_RDATA_IDLE: assert property (!$past(bus_read) |-> bus_rdata == 16'h0000)
        else $error("read data without a read");
    AST_OSC_DOWN: assert property ((!osc_bypass_select_n) [*4] |-> osc_power_down)
        else $error("oscillator powered in bypass");
    AST_PLL_ON: assert property (bus_write && pri_sel && bus_wdata[7] && !bus_wdata[3]
        |-> ##2 pll_power_up) else $error("pll not powered");
    AST_PLL_OFF: assert property (bus_write && pri_sel && !bus_wdata[7]
        |-> ##2 !pll_power_up) else $error("pll powered while deselected");
    AST_LOCK_TIME: assert property ($past(bus_read && pri_sel) && bus_rdata[5]
        |-> on_cnt >= LOCK_CYCLES) else $error("lock reported too early");
    AST_PERIPH_GAP: assert property (peripheral_clock_en |=> !peripheral_clock_en)
        else $error("peripheral clock faster than half");
    AST_WD_HIGH: assert property ($rose(watchdog_tick_clock) |-> watchdog_tick_clock [*2])
        else $error("watchdog high phase short");
    AST_WD_LOW: assert property ($fell(watchdog_tick_clock) |-> (!watchdog_tick_clock) [*6])
        else $error("watchdog low phase short");
    AST_IDLE_STOP: assert property (idle_request && !wake_request
        |-> ##3 (!core_clock_en) [*4]) else $error("core clock runs in idle");
endmodule // pll_clock_gen_chk

bind pll_clock_gen pll_clock_gen_chk #(.LOCK_CYCLES(LOCK_CYCLES),
    .WD_QUARTER_TICKS(WD_QUARTER_TICKS)) chk_inst (.core_clk(core_clk), .reset(reset),
    .ref_clock_in(ref_clock_in), .osc_bypass_select_n(osc_bypass_select_n),
    .crystal_drive_out(crystal_drive_out), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .idle_request(idle_request), .wake_request(wake_request),
    .core_clock_en(core_clock_en), .peripheral_clock_en(peripheral_clock_en),
    .watchdog_tick_clock(watchdog_tick_clock), .pll_power_up(pll_power_up),
    .osc_power_down(osc_power_down));

/* File: dv/pll_clock_gen_tb.sv */
/*
 * self-checking bench for pll_clock_gen with a cpu bus model.
 * assumes short LOCK_CYCLES and WD_QUARTER_TICKS for simulation.
 */
`timescale 1ns/10ps
module pll_clock_gen_tb;
    localparam [15:0] PRI = 16'h702A;
    localparam [15:0] MUL = 16'h702C;
    reg         core_clk            = 1'b0;
    reg         reset               = 1'b1;
    reg         ref_clock_in        = 1'b0;
    reg         osc_bypass_select_n = 1'b1;
    reg         idle_request        = 1'b0;
    reg         wake_request        = 1'b0;
    wire [15:0] bus_addr, bus_wdata, bus_rdata;
    wire        bus_write, bus_read, crystal_drive_out, core_clock_en;
    wire        peripheral_clock_en, watchdog_tick_clock, pll_power_up, osc_power_down;
    integer     n_errors = 0, checks_done = 0, ref_edges = 0;
    integer     nc, np, nx, ne, e0, i, k, f;
    reg [15:0]  rv, wv;
    always #10 core_clk = ~core_clk;
    always #207 ref_clock_in = ~ref_clock_in;
    always @(posedge ref_clock_in) ref_edges = ref_edges + 1;
    pll_clock_gen #(.LOCK_CYCLES(20), .WD_QUARTER_TICKS(2)) pll_clock_gen_inst (
        .core_clk(core_clk), .reset(reset), .ref_clock_in(ref_clock_in),
        .osc_bypass_select_n(osc_bypass_select_n), .crystal_drive_out(crystal_drive_out),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_rdata(bus_rdata), .idle_request(idle_request),
        .wake_request(wake_request), .core_clock_en(core_clock_en),
        .peripheral_clock_en(peripheral_clock_en), .watchdog_tick_clock(watchdog_tick_clock),
        .pll_power_up(pll_power_up), .osc_power_down(osc_power_down));
    cpu_bus_model cpu_bus_model_inst (.core_clk(core_clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task end_sim;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
                n_errors = n_errors + 1;
            end
        end
    endtask
    task near(input integer s, input integer e, input integer tol);
        chk({15'h0000, (s - e <= tol) && (e - s <= tol)}, 16'h0001);
    endtask
    function integer factor(input [2:0] c);
        case (c)
            3'd1: factor = 2;
            3'd2: factor = 3;
            3'd3: factor = 4;
            3'd4: factor = 5;
            3'd5: factor = 9;
            default: factor = 1;
        endcase
    endfunction
    task measure(input integer n);
        begin
            nc = 0; np = 0; nx = 0; e0 = ref_edges;
            repeat (n) begin
                @(negedge core_clk);
                nc = nc + core_clock_en;
                np = np + peripheral_clock_en;
                nx = nx + crystal_drive_out;
            end
            ne = ref_edges - e0;
        end
    endtask
    task pulse(input integer which);
        begin
            @(negedge core_clk);
            if (which == 0) idle_request = 1'b1; else wake_request = 1'b1;
            @(negedge core_clk);
            idle_request = 1'b0;
            wake_request = 1'b0;
            repeat (5) @(negedge core_clk);
        end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rv = $urandom(32'h8a7d);
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
        repeat (3) @(negedge core_clk);
        cpu_bus_model_inst.rd(PRI, rv); chk(rv, 16'h0000);
        cpu_bus_model_inst.rd(MUL + 16'h0001, rv); chk(rv, 16'h0000);
        for (i = 0; i < 16; i = i + 1) begin
            wv = $urandom;
            cpu_bus_model_inst.wr(PRI | i[0], wv);
            cpu_bus_model_inst.rd(PRI | !i[0], rv); chk(rv & 16'hFFDF, wv & 16'h00CD);
            wv = $urandom;
            cpu_bus_model_inst.wr(MUL | i[0], wv);
            cpu_bus_model_inst.rd(MUL | !i[0], rv); chk(rv, wv & 16'h00FF);
        end
        cpu_bus_model_inst.wr(16'h702E, wv);
        cpu_bus_model_inst.rd(16'h702E, rv); chk(rv, 16'h0000);
        $display("registers done");
        for (i = 0; i < 2; i = i + 1) begin
            cpu_bus_model_inst.wr(PRI, {8'h00, 1'b0, i[0], 5'h00, i[0]});
            repeat (5) @(negedge core_clk);
            measure(1000);
            near(nc * (i ? 1 : 2), ne, 3);
            near(np * (i ? 2 : 4), nc, 4);
        end
        $display("reference modes done");
        for (i = 0; i < 16; i = i + 1) begin
            f = factor(i[2:0]);
            wv = $urandom;
            cpu_bus_model_inst.wr(MUL, {8'h00, wv[3:0], i[3:0]});
            wv = {8'h00, 1'b1, i[0], 6'h01};
            cpu_bus_model_inst.wr(PRI, wv);
            cpu_bus_model_inst.rd(PRI, rv); chk(rv, wv);
            k = 0;
            while (!rv[5] && k < 100) begin
                cpu_bus_model_inst.rd(PRI, rv);
                k = k + 1;
            end
            chk(rv, wv | 16'h0020);
            if (!rv[5]) end_sim;
            chk(pll_power_up, 1);
            measure(1000);
            near(nc * 2, ne * f * (i[3] ? 1 : 2), 24);
            near(np * 2, nc, 4);
            cpu_bus_model_inst.wr(MUL, {8'h00, 4'h0, ~i[3:0]});
            measure(1000);
            near(nc * 2, ne * f * (i[3] ? 1 : 2), 24);
            cpu_bus_model_inst.wr(PRI, 16'h0020);
            cpu_bus_model_inst.rd(PRI, rv); chk(rv, 16'h0000);
            chk(pll_power_up, 0);
        end
        $display("pll factors done");
        for (i = 0; i < 4; i = i + 1) begin
            cpu_bus_model_inst.wr(PRI, {8'h00, 2'b01, 2'b00, i[1:0], 2'b01});
            repeat (5) @(negedge core_clk);
            pulse(0);
            measure(200);
            chk(nc, 0);
            chk(np > 0, i == 0);
            chk(osc_power_down, i == 3);
            pulse(1);
            measure(200);
            chk(nc > 0, 1);
        end
        $display("low power done");
        @(negedge core_clk);
        osc_bypass_select_n = 1'b0;
        repeat (6) @(negedge core_clk);
        measure(200);
        chk(osc_power_down, 1);
        chk(nx, 0);
        chk(nc > 0, 1);
        osc_bypass_select_n = 1'b1;
        repeat (6) @(negedge core_clk);
        measure(200);
        chk(osc_power_down, 0);
        chk(nx > 0, 1);
        $display("bypass done");
        end_sim;
    end
endmodule // pll_clock_gen_tb

/* File: hdl/clock_gen_consts.vh */
/*
 * constants for the clock generation block: register addresses, field
 * positions, reset values and timing counts. assumes a 50 MHz core_clk.
 */
`ifndef CLOCK_GEN_CONSTS_VH
`define CLOCK_GEN_CONSTS_VH

// ----------------------------------------------------------------------
// register addresses (word pair, odd alias)
// ----------------------------------------------------------------------
`define ADDR_CLOCK_CONTROL_PRIMARY    16'h702A
`define ADDR_CLOCK_CONTROL_MULTIPLIER 16'h702C

// ----------------------------------------------------------------------
// clock_control_primary fields
// ----------------------------------------------------------------------
`define SRC_HI            7
`define SRC_LO            6
`define LOCKED_BIT        5
`define LPM_HI            3
`define LPM_LO            2
`define PRESCALE_BIT      0
`define PRIMARY_RESET     8'h00

// ----------------------------------------------------------------------
// clock_control_multiplier fields
// ----------------------------------------------------------------------
`define FREQ_HI           7
`define FREQ_LO           4
`define HALVE_BIT         3
`define MULT_HI           2
`define MULT_LO           0
`define MULTIPLIER_RESET  8'h00

// ----------------------------------------------------------------------
// clock source and low power codes
// ----------------------------------------------------------------------
`define SRC_REF_HALF      2'b00
`define LPM_IDLE1         2'b00
`define LPM_OSC_DOWN      2'b11

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     20
`define LOCK_TIME_NS      100000
`define LOCK_CYCLES       ((`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_NOMINAL_HZ   20000000
`define WD_NOMINAL_HZ     16384
`define WD_QUARTER_TICKS  (`CORE_NOMINAL_HZ / (`WD_NOMINAL_HZ * 4))

`endif

/* File: hdl/pll_clock_gen.v */
/*
 * clock generation block: reference select, source select, pll model with
 * lock counter, peripheral and watchdog dividers, low power gating and the
 * two 8-bit control registers on the 16-bit peripheral bus.
 * assumes one core_clk at 50 MHz; core and peripheral clocks are one-cycle enables.
 */
`timescale 1ns/10ps
`include "clock_gen_consts.vh"

// How it works
// - 8-bit peripheral on 16-bit bus; upper byte reads zero, writes ignored
// - core clock is fastest; all other clocks are divided from it
// - peripheral clock runs at half or quarter of core clock
// - watchdog tick clock nominal 16 kHz, high one quarter of period
// - bypass select low uses external reference, high uses crystal oscillator
// - crystal oscillator powered down while bypass is selected
// - source field: 00 reference halved, 01 reference direct, 1x pll
// - pll powered only while upper source bit is one
// - lock counter runs after pll enable; pll clocks used after rollover
// - power-on reset clears the lock counter
// - lock status reads one only after lock counter rollover
// - three-bit multiplier selects factor 1, 2, 3, 4, 5 or 9
// - halve bit divides pll input by two before multiplying
// - each register also answers at the next odd address
// - multiplier register holds multiplier and input frequency code
// - primary register holds source, low power, prescale and status
// - low power bits choose which domains stop on idle
// - prescale bit zero divides core by four, one by two
// - two-bit low power field picks one of four idle modes
// - switch to pll clock automatically and glitch free after rollover
// - multiplier changes ignored until pll is turned off (deselected or deeper idle) and re-enabled
module pll_clock_gen #(
    parameter LOCK_CYCLES      = `LOCK_CYCLES,
    parameter WD_QUARTER_TICKS = `WD_QUARTER_TICKS
) (
    // clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // pins
    input  wire        ref_clock_in,
    input  wire        osc_bypass_select_n,
    output reg         crystal_drive_out,
    // peripheral bus
    input  wire [15:0] bus_addr,
    input  wire [15:0] bus_wdata,
    input  wire        bus_write,
    input  wire        bus_read,
    output reg  [15:0] bus_rdata,
    // cpu idle handshake
    input  wire        idle_request,
    input  wire        wake_request,
    // generated clock enables
    output reg         core_clock_en,
    output reg         peripheral_clock_en,
    output reg         watchdog_tick_clock,
    // power controls
    output reg         pll_power_up,
    output reg         osc_power_down
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg ref_s1_reg;
    reg ref_s2_reg;
    reg ref_s3_reg;
    reg byp_s1_reg;
    reg byp_s2_reg;

    always @(posedge core_clk) begin
        ref_s1_reg <= ref_clock_in;
        ref_s2_reg <= ref_s1_reg;
        ref_s3_reg <= ref_s2_reg;
        byp_s1_reg <= osc_bypass_select_n;
        byp_s2_reg <= byp_s1_reg;
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    reg  [1:0] clock_source_select_reg;
    reg  [1:0] low_power_mode_select_reg;
    reg        periph_prescale_select_reg;
    reg  [3:0] input_freq_code_reg;
    reg        pll_input_halve_reg;
    reg  [2:0] pll_multiplier_select_reg;
    reg        pll_locked_flag_reg;
    reg        idle_reg;

    localparam [7:0] PRIMARY_RST    = `PRIMARY_RESET;
    localparam [7:0] MULTIPLIER_RST = `MULTIPLIER_RESET;
    wire       sel_primary;
    wire       sel_multiplier;
    wire [7:0] primary_value;
    wire [7:0] multiplier_value;

    assign sel_primary    = (bus_addr[15:1] == `ADDR_CLOCK_CONTROL_PRIMARY >> 1);
    assign sel_multiplier = (bus_addr[15:1] == `ADDR_CLOCK_CONTROL_MULTIPLIER >> 1);

    assign primary_value = {clock_source_select_reg, pll_locked_flag_reg, 1'b0,
                            low_power_mode_select_reg, 1'b0,
                            periph_prescale_select_reg};
    assign multiplier_value = {input_freq_code_reg, pll_input_halve_reg,
                               pll_multiplier_select_reg};

    always @(posedge core_clk) begin
        if (reset) begin
            clock_source_select_reg    <= PRIMARY_RST[`SRC_HI:`SRC_LO];
            low_power_mode_select_reg  <= PRIMARY_RST[`LPM_HI:`LPM_LO];
            periph_prescale_select_reg <= PRIMARY_RST[`PRESCALE_BIT];
            input_freq_code_reg        <= MULTIPLIER_RST[`FREQ_HI:`FREQ_LO];
            pll_input_halve_reg        <= MULTIPLIER_RST[`HALVE_BIT];
            pll_multiplier_select_reg  <= MULTIPLIER_RST[`MULT_HI:`MULT_LO];
            bus_rdata                  <= 16'h0000;
        end else begin
            if (bus_write && sel_primary) begin
                // upper byte and status bit are not writable
                clock_source_select_reg    <= bus_wdata[`SRC_HI:`SRC_LO];
                low_power_mode_select_reg  <= bus_wdata[`LPM_HI:`LPM_LO];
                periph_prescale_select_reg <= bus_wdata[`PRESCALE_BIT];
            end
            if (bus_write && sel_multiplier) begin
                input_freq_code_reg       <= bus_wdata[`FREQ_HI:`FREQ_LO];
                pll_input_halve_reg       <= bus_wdata[`HALVE_BIT];
                pll_multiplier_select_reg <= bus_wdata[`MULT_HI:`MULT_LO];
            end
            if (bus_read && sel_primary)
                bus_rdata <= {8'h00, primary_value};
            else if (bus_read && sel_multiplier)
                bus_rdata <= {8'h00, multiplier_value};
            else
                bus_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // low power state
    // ------------------------------------------------------------------
    wire osc_off_idle;
    wire cpu_run;
    wire sys_run;

    assign osc_off_idle = idle_reg && (low_power_mode_select_reg == `LPM_OSC_DOWN);
    assign cpu_run      = !idle_reg;
    assign sys_run      = !idle_reg ||
                          (low_power_mode_select_reg == `LPM_IDLE1);

    always @(posedge core_clk) begin
        if (reset)
            idle_reg <= 1'b0;
        else if (wake_request)
            idle_reg <= 1'b0;
        else if (idle_request)
            idle_reg <= 1'b1;
    end

    // ------------------------------------------------------------------
    // pll enable, setting latch and lock counter
    // ------------------------------------------------------------------
    reg  [15:0] lock_count_reg;
    reg         pll_on_d_reg;
    reg  [2:0]  active_mult_reg;
    reg         active_halve_reg;
    wire        pll_on;

    // pll off in deeper idle modes
    assign pll_on = clock_source_select_reg[1] &&
                    !(idle_reg && low_power_mode_select_reg[1]);

    always @(posedge core_clk) begin
        if (reset) begin
            lock_count_reg      <= 16'h0000;
            pll_locked_flag_reg <= 1'b0;
            pll_on_d_reg        <= 1'b0;
            active_mult_reg     <= 3'b000;
            active_halve_reg    <= 1'b0;
        end else begin
            pll_on_d_reg <= pll_on;
            if (!pll_on) begin
                lock_count_reg      <= 16'h0000;
                pll_locked_flag_reg <= 1'b0;
            end else if (!pll_on_d_reg) begin
                // settings taken only when the pll is (re)enabled
                active_mult_reg  <= pll_multiplier_select_reg;
                active_halve_reg <= pll_input_halve_reg;
                lock_count_reg   <= 16'h0000;
            end else if (!pll_locked_flag_reg) begin
                if (lock_count_reg == LOCK_CYCLES - 1)
                    pll_locked_flag_reg <= 1'b1;
                else
                    lock_count_reg <= lock_count_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // pll rate model: factor times reference rate
    // ------------------------------------------------------------------
    reg  [4:0]  factor_x2;
    reg  [4:0]  factor_eff;
    reg  [15:0] ref_count_reg;
    reg  [15:0] ref_period_reg;
    reg  [17:0] phase_reg;
    reg         half_phase_reg;
    wire        ref_edge;
    wire [17:0] phase_sum;
    wire [17:0] phase_limit;
    wire        pll_tick;

    assign ref_edge = ref_s2_reg && !ref_s3_reg && !osc_off_idle;

    always @* begin
        case (active_mult_reg)
            3'b000:  factor_x2 = 5'd2;
            3'b001:  factor_x2 = 5'd4;
            3'b010:  factor_x2 = 5'd6;
            3'b011:  factor_x2 = 5'd8;
            3'b100:  factor_x2 = 5'd10;
            3'b101:  factor_x2 = 5'd18;
            default: factor_x2 = 5'd2;
        endcase
        factor_eff = active_halve_reg ? {1'b0, factor_x2[4:1]} : factor_x2;
    end

    assign phase_sum   = phase_reg + {13'h0000, factor_eff};
    assign phase_limit = {1'b0, ref_period_reg, 1'b0};
    assign pll_tick    = pll_locked_flag_reg && (phase_sum >= phase_limit);

    always @(posedge core_clk) begin
        if (reset) begin
            ref_count_reg  <= 16'h0000;
            ref_period_reg <= 16'hFFFF;
            phase_reg      <= 18'h0_0000;
            half_phase_reg <= 1'b0;
        end else begin
            if (ref_edge) begin
                ref_count_reg  <= 16'h0000;
                ref_period_reg <= ref_count_reg + 16'h0001;
                half_phase_reg <= !half_phase_reg;
            end else if (ref_count_reg != 16'hFFFF) begin
                ref_count_reg <= ref_count_reg + 16'h0001;
            end
            if (!pll_locked_flag_reg)
                phase_reg <= 18'h0_0000;
            else if (pll_tick)
                phase_reg <= phase_sum - phase_limit;
            else
                phase_reg <= phase_sum;
        end
    end

    // ------------------------------------------------------------------
    // core clock source select
    // ------------------------------------------------------------------
    reg  core_tick_reg;
    wire bypass_tick;

    // before lock the low source bit picks halved or direct reference
    assign bypass_tick = (clock_source_select_reg[0] == 1'b0) ?
                         (ref_edge && half_phase_reg) : ref_edge;

    always @(posedge core_clk) begin
        if (reset) begin
            core_tick_reg <= 1'b0;
            core_clock_en <= 1'b0;
        end else begin
            // whole pulses only, handover at lock is glitch free
            core_tick_reg <= pll_locked_flag_reg ? pll_tick : bypass_tick;
            core_clock_en <= (pll_locked_flag_reg ? pll_tick : bypass_tick)
                             && cpu_run;
        end
    end

    // ------------------------------------------------------------------
    // peripheral and watchdog dividers
    // ------------------------------------------------------------------
    wire        periph_tick;
    wire        wd_quarter_tick;
    reg  [1:0]  wd_phase_reg;

    tick_divider #(
        .WIDTH   (3)
    ) periph_div (
        .core_clk(core_clk),
        .reset   (reset),
        .en      (core_tick_reg),
        .divisor (periph_prescale_select_reg ? 3'd2 : 3'd4),
        .tick    (periph_tick)
    );

    tick_divider #(
        .WIDTH   (16)
    ) wd_div (
        .core_clk(core_clk),
        .reset   (reset),
        .en      (core_tick_reg && !osc_off_idle),
        .divisor (WD_QUARTER_TICKS[15:0]),
        .tick    (wd_quarter_tick)
    );

    always @(posedge core_clk) begin
        if (reset) begin
            wd_phase_reg        <= 2'b00;
            watchdog_tick_clock <= 1'b0;
            peripheral_clock_en <= 1'b0;
        end else begin
            if (wd_quarter_tick)
                wd_phase_reg <= wd_phase_reg + 2'b01;
            watchdog_tick_clock <= (wd_phase_reg == 2'b00);
            peripheral_clock_en <= periph_tick && sys_run;
        end
    end

    // ------------------------------------------------------------------
    // power controls and crystal drive
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (reset) begin
            pll_power_up      <= 1'b0;
            osc_power_down    <= 1'b1;
            crystal_drive_out <= 1'b0;
        end else begin
            pll_power_up      <= pll_on;
            osc_power_down    <= !byp_s2_reg || osc_off_idle;
            crystal_drive_out <= byp_s2_reg && !osc_off_idle && !ref_s2_reg;
        end
    end

endmodule // pll_clock_gen

/* File: hdl/tick_divider.v */
/*
 * counts enable pulses and emits one pulse every divisor of them.
 * assumes divisor is at least 1 and only changes between pulses.
 */
`timescale 1ns/10ps

module tick_divider #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             reset,
    // count control
    input  wire             en,
    input  wire [WIDTH-1:0] divisor,
    // divided pulse
    output reg              tick
);

    reg [WIDTH-1:0] count_reg;

    always @(posedge core_clk) begin
        if (reset) begin
            count_reg <= {WIDTH{1'b0}};
            tick      <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (count_reg >= divisor - 1'b1) begin
                    count_reg <= {WIDTH{1'b0}};
                    tick      <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end

endmodule // tick_divider
